//--- hdl/asr_host.sv
// asr_host: host controller driving a 128K x 8 asynchronous static ram
// assumes the sram pins are wired straight to these ports; single 100 MHz clock
`timescale 1ns/1ps
module asr_host #(
    parameter int ADDR_W = asr_pkg::ADDR_W,
    parameter int DATA_W = asr_pkg::DATA_W
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // user request
    input wire logic i_req_valid,
    input wire asr_pkg::asr_req_t i_req,
    output logic o_req_ready,
    // user answer
    output logic o_rd_valid,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_wr_done,
    // sram pins
    output logic [ADDR_W-1:0] o_sram_addr,
    output asr_pkg::asr_strobe_t o_sram_strobe,
    input wire logic [DATA_W-1:0] i_sram_dq,
    output logic [DATA_W-1:0] o_sram_dq,
    output logic o_sram_dq_oe
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD = 3'h1,
        ST_TURN = 3'h3,
        ST_WSET = 3'h2,
        ST_WPUL = 3'h6,
        ST_WEND = 3'h7
    } asr_state_t;

    // every count must stay below 16 to fit cnt_q
    localparam logic [3:0] RD_N = 4'(asr_pkg::RD_CYC);
    localparam logic [3:0] TURN_N = 4'(asr_pkg::TURN_CYC);
    localparam logic [3:0] WHZ_N = 4'(asr_pkg::WHZ_CYC);
    localparam logic [3:0] WP_N = 4'(asr_pkg::WP_CYC);

    asr_state_t state_q;
    logic [3:0] cnt_q;
    logic [DATA_W-1:0] dq_sync;
    logic rd_last;

    asr_sync3 #(
        .W(DATA_W)
    ) u_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_async(i_sram_dq),
        .o_sync(dq_sync)
    );

    // sequencing; each state but ST_IDLE and ST_WEND holds pins for cnt cycles
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (i_req_valid)
                    begin
                        state_q <= i_req.write ? ST_WSET : ST_RD;
                        cnt_q <= i_req.write ? WHZ_N : RD_N;
                    end
                end
                ST_RD:
                begin
                    // write strobe stays high for the whole window
                    if (cnt_q == 4'h1)
                    begin
                        state_q <= ST_TURN;
                        cnt_q <= TURN_N; // device release before next bus use
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                ST_TURN:
                begin
                    if (cnt_q == 4'h1)
                        state_q <= ST_IDLE;
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                ST_WSET:
                begin
                    // wait out turn-off after we falls before driving data
                    if (cnt_q == 4'h1)
                    begin
                        state_q <= ST_WPUL;
                        cnt_q <= WP_N;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                ST_WPUL:
                begin
                    if (cnt_q == 4'h1)
                        state_q <= ST_WEND;
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                ST_WEND:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // address latched at the same edge that drops the strobes
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_sram_addr <= '0;
        else if (state_q == ST_IDLE && i_req_valid)
            o_sram_addr <= i_req.addr; // 17-bit word address
    end

    // strobes: cs and we fall together on writes so the device stays off
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_sram_strobe <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (i_req_valid && i_req.write)
                        o_sram_strobe <= '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
                    else if (i_req_valid)
                        o_sram_strobe <= '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
                    else
                        o_sram_strobe <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                end
                ST_RD:
                    if (cnt_q == 4'h1)
                        o_sram_strobe <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                ST_WPUL:
                    // we and cs rise together, ending the write after full pulse
                    if (cnt_q == 4'h1)
                        o_sram_strobe <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                default:
                    ;
            endcase
        end
    end

    // data drive: on from pulse start, kept one cycle past write end for hold
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_sram_dq <= '0;
            o_sram_dq_oe <= 1'b0;
        end
        else
        begin
            if (state_q == ST_IDLE && i_req_valid)
                o_sram_dq <= i_req.wdata;
            if (state_q == ST_WSET && cnt_q == 4'h1)
                o_sram_dq_oe <= 1'b1;
            else if (state_q == ST_WEND || state_q == ST_IDLE)
                o_sram_dq_oe <= 1'b0;
        end
    end

    // last read cycle: strobes rise and the synced byte is taken at one edge
    assign rd_last = (state_q == ST_RD) && (cnt_q == 4'h1);

    // answers; the window covers access time plus four sync stages, since a
    // shorter one would hand back the byte of the previous read
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rd_valid <= 1'b0;
            o_rd_data <= '0;
            o_wr_done <= 1'b0;
            o_req_ready <= 1'b0;
        end
        else
        begin
            o_rd_valid <= rd_last;
            if (rd_last)
                o_rd_data <= dq_sync;
            o_wr_done <= (state_q == ST_WEND);
            o_req_ready <= (state_q == ST_IDLE && !i_req_valid) ||
                           (state_q == ST_TURN && cnt_q == 4'h1) || (state_q == ST_WEND);
        end
    end
endmodule

//--- inc/asr_pkg.sv
// asr_pkg: constants and carriers for the async sram host controller
// assumes a 100 MHz single clock; all times in ns, cycle counts derived
package asr_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 10;

    // worst grade figures so one build fits every grade
    localparam int T_RC_NS = 20;
    localparam int T_AA_NS = 20;
    localparam int T_OHZ_NS = 7;
    localparam int T_CHZ_NS = 8;
    localparam int T_WHZ_NS = 8;
    localparam int T_WP_NS = 15;
    localparam int T_CW_NS = 15;
    localparam int T_AW_NS = 15;
    localparam int T_DW_NS = 9;
    localparam int T_WC_NS = 20;

    // least times round up; a read adds one sample cycle plus four sync stages
    localparam int SYNC_CYC = 4;
    localparam int RD_CYC = (T_AA_NS + CLK_NS - 1) / CLK_NS + 1 + SYNC_CYC;
    localparam int TURN_CYC = (T_OHZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int WHZ_CYC = (T_WHZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int DW_CYC = (T_DW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = ((T_WP_NS + CLK_NS - 1) / CLK_NS > WHZ_CYC + DW_CYC) ?
                            (T_WP_NS + CLK_NS - 1) / CLK_NS : WHZ_CYC + DW_CYC;
    localparam int CNT_W = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
    } asr_req_t;

    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
    } asr_strobe_t;
endpackage

//--- hdl/asr_sync3.sv
// asr_sync3: three-flop pin synchroniser, change taken when stages 2 and 3 agree
// assumes one clock domain; input asynchronous to it
`timescale 1ns/1ps
module asr_sync3 #(
    parameter int W = 8
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_sync <= '0;
        else if (s2_q == s3_q)
            o_sync <= s3_q;
    end
endmodule

//--- verif/asr_sram_model.sv
// asr_sram_model: behavioural 128K x 8 asynchronous sram
// assumes host pins wired straight in; access delay set by parameter
`timescale 1ns/1ps
module asr_sram_model #(
    parameter int T_ACC_NS = 12
)
(
    // pins
    input wire logic [16:0] i_addr,
    input wire asr_pkg::asr_strobe_t i_strobe,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq
);
    logic [7:0] mem_q [0:131071];
    logic [7:0] last_q = 8'h00;
    wire drive = !i_strobe.cs_n && !i_strobe.oe_n && i_strobe.we_n;
    wire wr_act = !i_strobe.cs_n && !i_strobe.we_n;
    // released bus shows the inverse so a stale value never passes
    assign #(T_ACC_NS) o_dq = drive ? mem_q[i_addr] : ~last_q;
    always @*
        if (drive)
            last_q = mem_q[i_addr];
    always @(negedge wr_act)
        mem_q[i_addr] = i_dq;
endmodule

//--- verif/asr_host_sva.sv
// asr_host_sva: pin timing checks for the sram host controller
// assumes a single clock; bound to asr_host below
`timescale 1ns/1ps
module asr_host_sva (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // answers and pins
    input wire logic o_rd_valid,
    input wire logic o_wr_done,
    input wire logic [16:0] o_sram_addr,
    input wire asr_pkg::asr_strobe_t o_sram_strobe,
    input wire logic [7:0] o_sram_dq,
    input wire logic o_sram_dq_oe
);
    wire cs_n = o_sram_strobe.cs_n;
    wire oe_n = o_sram_strobe.oe_n;
    wire we_n = o_sram_strobe.we_n;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    a_we_high_read: assert property (!oe_n |-> we_n)
        else $error("write strobe low in read");
    a_no_bus_fight: assert property (o_sram_dq_oe |-> oe_n && $past(oe_n))
        else $error("host drives while sram may drive");
    a_cs_with_we: assert property ($fell(we_n) |-> $fell(cs_n) && !o_sram_dq_oe)
        else $error("select not falling with write strobe");
    a_write_pulse: assert property ($fell(we_n) |-> (!we_n && !cs_n) [*2])
        else $error("write pulse too short");
    a_addr_held: assert property ((!cs_n) [*2] |-> $stable(o_sram_addr))
        else $error("address moved while selected");
    a_data_held: assert property ($rose(we_n) |-> o_sram_dq_oe && $stable(o_sram_dq))
        else $error("write data not held to write end");
    a_read_answer: assert property ($fell(oe_n) |-> ##[3:8] o_rd_valid)
        else $error("read answer missing");
    a_write_answer: assert property ($rose(we_n) |-> ##[0:2] o_wr_done)
        else $error("write done missing");
endmodule
bind asr_host asr_host_sva asr_host_sva_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .o_rd_valid(o_rd_valid), .o_wr_done(o_wr_done), .o_sram_addr(o_sram_addr),
    .o_sram_strobe(o_sram_strobe), .o_sram_dq(o_sram_dq), .o_sram_dq_oe(o_sram_dq_oe));

//--- verif/testbench.sv
// testbench: host controller against the sram model
// assumes one 100 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
module testbench;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_req_valid = 1'b0;
    asr_pkg::asr_req_t i_req = '0;
    logic o_req_ready, o_rd_valid, o_wr_done, o_sram_dq_oe, done;
    logic [7:0] o_rd_data, o_sram_dq, ram_dq, bus_dq;
    logic [16:0] o_sram_addr;
    asr_pkg::asr_strobe_t o_sram_strobe;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    assign bus_dq = o_sram_dq_oe ? o_sram_dq : ram_dq;
    initial forever #5 i_clock = ~i_clock;
    asr_host asr_host_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_wr_done(o_wr_done), .o_sram_addr(o_sram_addr),
        .o_sram_strobe(o_sram_strobe), .i_sram_dq(bus_dq), .o_sram_dq(o_sram_dq),
        .o_sram_dq_oe(o_sram_dq_oe));
    // slowest grade access so the read sampling margin is exercised
    asr_sram_model #(.T_ACC_NS(20)) asr_sram_model_inst (.i_addr(o_sram_addr),
        .i_strobe(o_sram_strobe), .i_dq(bus_dq), .o_dq(ram_dq));
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (exp !== got)
        begin
            failures++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [16:0] a, input logic [7:0] d);
        @(negedge i_clock);
        repeat (20)
            if (o_req_ready !== 1'b1)
                @(negedge i_clock);
        chk(32'h1, o_req_ready);
        i_req = '{addr: a, wdata: d, write: wr};
        i_req_valid = 1'b1;
        @(negedge i_clock);
        i_req_valid = 1'b0;
        done = 1'b0;
        repeat (20)
            if (done !== 1'b1)
            begin
                @(posedge i_clock);
                #1;
                done = wr ? o_wr_done : o_rd_valid;
            end
    endtask
    task automatic t_idle();
        chk(32'h7, o_sram_strobe);
        chk(32'h0, o_sram_dq_oe);
        $display("test idle done");
    endtask
    task automatic t_write_read();
        logic [16:0] adr [3] = '{17'h00000, 17'h1ffff, 17'h0a5a5};
        logic [7:0] dat [3] = '{8'h3c, 8'hc3, 8'h5a};
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, adr[i], dat[i]);
            chk(32'h1, done);
        end
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b0, adr[i], 8'h00);
            chk(32'h1, done);
            chk(adr[i], o_sram_addr);
            chk(dat[i], o_rd_data);
            chk(32'h7, o_sram_strobe);
        end
        $display("test write_read done");
    endtask
    task automatic t_overwrite();
        xfer(1'b1, 17'h00000, 8'hff);
        xfer(1'b0, 17'h1ffff, 8'h00);
        chk(32'hc3, o_rd_data);
        xfer(1'b0, 17'h00000, 8'h00);
        chk(32'hff, o_rd_data);
        $display("test overwrite done");
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            complete_run();
        end
    end
    initial
    begin
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        i_rst_b = 1'b1;
        t_idle();
        t_write_read();
        t_overwrite();
        complete_run();
    end
endmodule
